//--- bench/atsc_host_model.sv
// Host side model that runs byte register cycles on the task file
`timescale 1ns/100ps
module atsc_host_model (
  input wire logic sys_clk_i, // System clock
  input wire logic busy_i, // Card busy level
  output atsc_pkg::atsc_off_t reg_addr_o, // Register offset
  output logic reg_wr_o, // Write strobe
  output logic reg_rd_o, // Read strobe
  output atsc_pkg::atsc_byte_t reg_wdata_o, // Write data
  input wire atsc_pkg::atsc_byte_t reg_rdata_i // Read data
);
  import atsc_pkg::*;
  // Idle bus at time zero
  initial begin
    reg_addr_o = 4'h0;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One write cycle; released lines show the inverse of the last value
  task automatic wr(input atsc_off_t a, input atsc_byte_t d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  // One read cycle; data is taken once the registered answer has landed
  task automatic rd(input atsc_off_t a, output atsc_byte_t d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    @(negedge sys_clk_i);
    d = reg_rdata_i;
  endtask : rd
  // Drive/head write: waits up to 64 cycles for a free card, fixed bits sent high
  task automatic wr_dh(input atsc_byte_t d);
    for (int n = 0; n < 64 && busy_i; n++) @(negedge sys_clk_i);
    wr(4'h6, d | 8'ha0);
  endtask : wr_dh
  // Control write with the spare bits sent as zero
  task automatic wr_ctl(input atsc_byte_t d);
    wr(4'he, d & 8'h06);
  endtask : wr_ctl
endmodule : atsc_host_model

//--- bench/atsc_taskfile_tb.sv
// Self-checking bench of the task file control block
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module atsc_taskfile_tb;
  import atsc_pkg::*;
  logic sys_clk = 1'b0; // Clock
  logic nrst = 1'b0; // Reset, low
  logic own = 1'b0; // Own card number
  logic irq_ev = 1'b0; // Interrupt event
  logic [7:0] eng = 8'h00; // Engine levels: busy,rdy,drq,wf,corrected_error_flag,err,wa,dma
  atsc_byte_t sec = 8'h00, cl = 8'h00, ch = 8'h00, dh = 8'ha0, d, rdata, wdata;
  atsc_off_t addr; // Offset
  logic wr, rd, dmarq, irq, intb, srst, csel; // Strobes and flags
  atsc_lba_t lba; // Block address
  logic [3:0] head; // Head number
  atsc_mode_e mode; // Scheme
  int mismatches = 0, samples_checked = 0, cyc = 0; // Counters
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  atsc_host_model h (.sys_clk_i(sys_clk), .busy_i(eng[0]), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  atsc_taskfile u_dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sector_i(sec), .cyl_lo_i(cl),
    .cyl_hi_i(ch), .copy_card_i(own), .busy_i(eng[0]), .ready_i(eng[1]), .drq_i(eng[2]),
    .write_fault_i(eng[3]), .corrected_error_flag_i(eng[4]), .err_i(eng[5]), .write_active_i(eng[6]),
    .dma_want_i(eng[7]), .irq_event_i(irq_ev), .dmarq_o(dmarq), .irq_o(irq),
    .int_bit_o(intb), .soft_reset_o(srst), .card_selected_o(csel), .lba_o(lba),
    .head_o(head), .mode_o(mode));
  // Expected status byte
  function automatic atsc_byte_t exp_st(input logic [7:0] e, input logic sr);
    if (e[0] || sr) return 8'h80;
    return {1'b0, e[1], e[3], e[1], e[2], e[4], 1'b0, e[5]};
  endfunction : exp_st
  // Expected drive address byte
  function automatic atsc_byte_t exp_da(input atsc_byte_t x, input logic wa, input logic o);
    return {1'b0, ~wa, ~x[3:0], ~(x[4] && o), ~(!x[4] && !o)};
  endfunction : exp_da
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // Reads every register and compares all outputs except irq and intb
  task automatic check_all(input logic sr);
    atsc_byte_t v;
    h.rd(4'h6, v);
    `CHK(v, dh)
    h.rd(4'h7, v);
    `CHK(v, exp_st(eng, sr))
    h.rd(4'he, v);
    `CHK(v, exp_st(eng, sr))
    h.rd(4'hf, v);
    `CHK(v, exp_da(dh, eng[6], own))
    `CHK(lba, {dh[3:0], ch, cl, sec})
    `CHK(head, dh[3:0])
    `CHK(mode, atsc_mode_e'(dh[6]))
    `CHK(csel, dh[4] == own)
    `CHK(dmarq, eng[7] && (eng[0] || eng[2]) && !sr)
    `CHK(srst, sr)
  endtask : check_all
  // Pulses the completion event
  task automatic pulse;
    @(negedge sys_clk);
    irq_ev = 1'b1;
    @(negedge sys_clk);
    irq_ev = 1'b0;
    @(negedge sys_clk);
  endtask : pulse
  // Main sequence
  initial begin
    void'($urandom(40));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    check_all(1'b0);
    `CHK(intb, 1'b0)
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      eng = 8'($urandom());
      if (i < 4) eng[0] = 1'b1;
      own = 1'($urandom());
      sec = 8'($urandom());
      cl = 8'($urandom());
      ch = 8'($urandom());
      d = 8'($urandom());
      if (eng[0]) h.wr(4'h6, d | 8'ha0);
      else begin
        h.wr_dh(d & 8'h5f);
        dh = d | 8'ha0;
      end
      if (!eng[0]) h.wr(4'h7, 8'hff);
      check_all(1'b0);
    end
    h.rd(4'h0, d);
    `CHK(d, 8'h00)
    eng = 8'h02;
    h.wr_ctl(8'h00);
    pulse();
    `CHK(intb, 1'b1)
    `CHK(irq, dh[4] == own)
    h.rd(4'he, d);
    `CHK(intb, 1'b1)
    h.rd(4'h7, d);
    `CHK(intb, 1'b0)
    h.wr_ctl(8'h02);
    pulse();
    `CHK(intb, 1'b0)
    `CHK(irq, 1'b0)
    h.rd(4'h7, d);
    eng = 8'h85;
    h.wr(4'he, 8'hfd);
    dh = 8'ha0;
    check_all(1'b1);
    eng = 8'h02;
    check_all(1'b1);
    h.wr_ctl(8'h00);
    check_all(1'b0);
    // Mid-run power-on reset with the interrupt masked and pending
    h.wr_ctl(8'h02);
    pulse();
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    dh = 8'ha0;
    check_all(1'b0);
    `CHK(intb, 1'b0)
    pulse();
    `CHK(intb, 1'b1)
    tally_and_finish();
  end
endmodule : atsc_taskfile_tb

//--- rtl/atsc_addr_build.sv
// Builds the block address and head number from the task file bytes
`timescale 1ns/100ps
`include "atsc_cfg.svh"
module atsc_addr_build (
  input wire logic sys_clk_i, // System clock
  input wire logic nrst_i, // Async reset, low
  input wire atsc_pkg::atsc_byte_t drive_head_i, // Drive/head byte
  input wire atsc_pkg::atsc_byte_t sector_i, // Sector number byte
  input wire atsc_pkg::atsc_byte_t cyl_lo_i, // Cylinder low byte
  input wire atsc_pkg::atsc_byte_t cyl_hi_i, // Cylinder high byte
  output atsc_pkg::atsc_lba_t lba_o, // Block address
  output logic [3:0] head_o, // Head number
  output atsc_pkg::atsc_mode_e mode_o // Address scheme
);
  import atsc_pkg::*;

  // Register the decoded address for the next command
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lba_o <= 28'h000_0000;
      head_o <= 4'h0;
      mode_o <= ATSC_CHS;
    end else begin
      mode_o <= drive_head_i[`ATSC_DH_LBA] ? ATSC_LBA : ATSC_CHS; // R02
      lba_o <= {drive_head_i[3:0], cyl_hi_i, cyl_lo_i, sector_i}; // R03
      head_o <= drive_head_i[3:0]; // R04
    end
  end
endmodule : atsc_addr_build

//--- rtl/atsc_cfg.svh
// Offsets, field positions and reset values of the task file control block
`ifndef ATSC_CFG_SVH
`define ATSC_CFG_SVH
`define ATSC_OFF_DRIVE_HEAD 4'h6
`define ATSC_OFF_STATUS 4'h7
`define ATSC_OFF_CTRL 4'he
`define ATSC_OFF_DRV_ADDR 4'hf
`define ATSC_OFF_SECTOR 4'h3
`define ATSC_OFF_CYL_LO 4'h4
`define ATSC_OFF_CYL_HI 4'h5
`define ATSC_DH_ONE_HI 7
`define ATSC_DH_LBA 6
`define ATSC_DH_ONE_LO 5
`define ATSC_DH_CARD 4
`define ATSC_ST_BUSY 7
`define ATSC_ST_RDY 6
`define ATSC_ST_DWF 5
`define ATSC_ST_DSC 4
`define ATSC_ST_DRQ 3
`define ATSC_ST_CORRECTED_ERROR_FLAG 2
`define ATSC_ST_IDX 1
`define ATSC_ST_ERR 0
`define ATSC_CTL_SRST 2
`define ATSC_CTL_IEN_N 1
`define ATSC_DH_RESET 8'ha0
`define ATSC_CTL_RESET 8'h00
`define ATSC_BYTE_ZERO 8'h00
`endif

//--- rtl/atsc_pkg.sv
// Types shared by the task file control block
package atsc_pkg;
  typedef logic [7:0] atsc_byte_t; // Register byte
  typedef logic [3:0] atsc_off_t; // Register offset
  typedef logic [27:0] atsc_lba_t; // Block address
  typedef enum logic {ATSC_CHS, ATSC_LBA} atsc_mode_e; // Address scheme
endpackage : atsc_pkg

//--- rtl/atsc_taskfile.sv
// Drive/head, status, device control and drive address registers of the task file
//
// Summary of operation
// R01: Drive/head bits 7,5 are ones, ignored
// R02: Drive/head bit 6 picks CHS or LBA
// R03: LBA built from sector, cylinders, head bits
// R04: CHS head number is drive/head bits 3-0
// R05: Drive/head bit 4 selects card 0/1
// R06: Own card number from copy field
// R07: Status read clears interrupt, alternate does not
// R08: Busy locks host out, masks other bits
// R09: DMA request only while busy or drq
// R10: Ready cleared at power up until ready
// R11: Bit 5 write fault, bit 4 ready
// R12: Bit 3 set when data transfer needed
// R13: Bit 2 flags corrected data error
// R14: Index bit always reads zero
// R15: Bit 0 flags previous command error
// R16: Failing sector address left in registers
// R17: Control writable while busy, spare bits ignored
// R18: Soft reset bit holds card in reset
// R19: Active-low interrupt enable, resets to zero
// R20: Drive address bit 6 low while writing
// R21: Drive address bits 5-2 inverted head bits
// R22: Drive address bits 1,0 low when selected
// R23: Host issues commands only when not busy
`timescale 1ns/100ps
`include "atsc_cfg.svh"
module atsc_taskfile (
  input wire logic sys_clk_i, // System clock, 100 MHz
  input wire logic nrst_i, // Async power-on reset, low
  input wire atsc_pkg::atsc_off_t reg_addr_i, // Register offset
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire atsc_pkg::atsc_byte_t reg_wdata_i, // Write data
  output atsc_pkg::atsc_byte_t reg_rdata_o, // Read data, registered
  input wire atsc_pkg::atsc_byte_t sector_i, // Sector number byte
  input wire atsc_pkg::atsc_byte_t cyl_lo_i, // Cylinder low byte
  input wire atsc_pkg::atsc_byte_t cyl_hi_i, // Cylinder high byte
  input wire logic copy_card_i, // Card number from copy field
  input wire logic busy_i, // Engine owns command block
  input wire logic ready_i, // Engine can accept commands
  input wire logic drq_i, // Engine needs data moved
  input wire logic write_fault_i, // Write fault seen
  input wire logic corrected_error_flag_i, // Corrected data error
  input wire logic err_i, // Previous command ended in error
  input wire logic write_active_i, // Write operation in progress
  input wire logic dma_want_i, // Engine wants a DMA transfer
  input wire logic irq_event_i, // Command completion event, pulse
  output logic dmarq_o, // DMA request
  output logic irq_o, // Interrupt request to host
  output logic int_bit_o, // Interrupt bit for config/status register
  output logic soft_reset_o, // Soft reset held
  output logic card_selected_o, // This card is addressed
  output atsc_pkg::atsc_lba_t lba_o, // Block address
  output logic [3:0] head_o, // Head number
  output atsc_pkg::atsc_mode_e mode_o // Address scheme
);
  import atsc_pkg::*;

  atsc_byte_t drive_head_r; // Drive/head register
  logic lba_sel_r; // Address scheme select
  logic card_number_select_r; // Selected card number
  logic soft_reset_bit_r; // Soft reset control
  logic interrupt_mask_n_r; // Interrupt disable, high blocks
  logic irq_pend_r; // Pending interrupt
  logic own_card_r; // Own card number
  atsc_byte_t status_now; // Live status byte
  atsc_byte_t drv_addr_now; // Live drive address byte
  logic selected; // Card number matches
  logic wr_dh; // Drive/head write
  logic wr_ctl; // Device control write
  logic rd_status; // Primary status read

  // Decode of a register access at one offset
  function automatic logic hit(input atsc_off_t a, input atsc_off_t off, input logic stb);
    hit = stb && (a == off);
  endfunction : hit

  assign wr_dh = hit(reg_addr_i, `ATSC_OFF_DRIVE_HEAD, reg_wr_i) && !busy_i; // R08
  assign wr_ctl = hit(reg_addr_i, `ATSC_OFF_CTRL, reg_wr_i); // R17
  assign rd_status = hit(reg_addr_i, `ATSC_OFF_STATUS, reg_rd_i);
  assign selected = (card_number_select_r == own_card_r);

  // Own card number taken from the copy field after reset release
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      own_card_r <= 1'b0;
    end else begin
      own_card_r <= copy_card_i; // R06
    end
  end

  // Drive/head register; bits 7 and 5 always stored as ones
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_head_r <= `ATSC_DH_RESET;
      lba_sel_r <= 1'b0;
      card_number_select_r <= 1'b0;
    end else if (soft_reset_bit_r) begin
      drive_head_r <= `ATSC_DH_RESET;
      lba_sel_r <= 1'b0;
      card_number_select_r <= 1'b0;
    end else if (wr_dh) begin
      drive_head_r <= {1'b1, reg_wdata_i[6], 1'b1, reg_wdata_i[4:0]}; // R01
      lba_sel_r <= reg_wdata_i[`ATSC_DH_LBA]; // R02
      card_number_select_r <= reg_wdata_i[`ATSC_DH_CARD]; // R05
    end
  end

  // Device control register, accepted even while busy
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      soft_reset_bit_r <= 1'b0;
      interrupt_mask_n_r <= 1'b0; // R19
    end else if (wr_ctl) begin
      soft_reset_bit_r <= reg_wdata_i[`ATSC_CTL_SRST]; // R18
      interrupt_mask_n_r <= reg_wdata_i[`ATSC_CTL_IEN_N]; // R19
    end
  end

  // Live status; busy masks the remaining bits
  always_comb begin
    status_now = `ATSC_BYTE_ZERO;
    if (busy_i || soft_reset_bit_r) begin
      status_now[`ATSC_ST_BUSY] = 1'b1; // R08
    end else begin
      status_now[`ATSC_ST_RDY] = ready_i; // R10
      status_now[`ATSC_ST_DWF] = write_fault_i; // R11
      status_now[`ATSC_ST_DSC] = ready_i; // R11
      status_now[`ATSC_ST_DRQ] = drq_i; // R12
      status_now[`ATSC_ST_CORRECTED_ERROR_FLAG] = corrected_error_flag_i; // R13
      status_now[`ATSC_ST_ERR] = err_i; // R15
    end
    status_now[`ATSC_ST_IDX] = 1'b0; // R14
  end

  // Live drive address byte; bit 7 driven low
  always_comb begin
    drv_addr_now = `ATSC_BYTE_ZERO;
    drv_addr_now[6] = !write_active_i; // R20
    drv_addr_now[5:2] = ~drive_head_r[3:0]; // R21
    drv_addr_now[1] = !(card_number_select_r && selected); // R22
    drv_addr_now[0] = !(!card_number_select_r && selected); // R22
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= `ATSC_BYTE_ZERO;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ATSC_OFF_DRIVE_HEAD: reg_rdata_o <= drive_head_r;
        `ATSC_OFF_STATUS: reg_rdata_o <= status_now; // R07
        `ATSC_OFF_CTRL: reg_rdata_o <= status_now; // R07
        `ATSC_OFF_DRV_ADDR: reg_rdata_o <= drv_addr_now;
        default: reg_rdata_o <= `ATSC_BYTE_ZERO;
      endcase
    end
  end

  // Pending interrupt; a new event wins over the clearing read
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_pend_r <= 1'b0;
    end else if (soft_reset_bit_r) begin
      irq_pend_r <= 1'b0;
    end else if (irq_event_i) begin
      irq_pend_r <= 1'b1;
    end else if (rd_status) begin
      irq_pend_r <= 1'b0; // R07
    end
  end

  // Registered outputs toward host and engine
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
      int_bit_o <= 1'b0;
      dmarq_o <= 1'b0;
      soft_reset_o <= 1'b0;
      card_selected_o <= 1'b1;
    end else begin
      irq_o <= irq_pend_r && !interrupt_mask_n_r && selected; // R19
      int_bit_o <= irq_pend_r && !interrupt_mask_n_r; // R19
      dmarq_o <= dma_want_i && (busy_i || drq_i) && !soft_reset_bit_r; // R09
      soft_reset_o <= soft_reset_bit_r; // R18
      card_selected_o <= selected; // R05
    end
  end

  // Address decode for the next command; the engine keeps the
  // failing sector address in the command block bytes it drives in
  atsc_addr_build u_addr (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .drive_head_i({drive_head_r[7], lba_sel_r, drive_head_r[5:0]}),
    .sector_i(sector_i), // R16
    .cyl_lo_i(cyl_lo_i),
    .cyl_hi_i(cyl_hi_i),
    .lba_o(lba_o),
    .head_o(head_o),
    .mode_o(mode_o)
  );

  // DMA request never stands without busy or drq one cycle earlier
  property p_dmarq_gated;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      dmarq_o |-> $past(busy_i) || $past(drq_i);
  endproperty
  a_dmarq_gated: assert property (p_dmarq_gated) else $error("dmarq without busy or drq"); // R09

  // Status read while busy shows only the busy bit
  property p_busy_mask;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (rd_status && busy_i) |=> reg_rdata_o == 8'h80;
  endproperty
  a_busy_mask: assert property (p_busy_mask) else $error("busy status not masked"); // R08

  // Index bit always zero on status reads
  property p_idx_zero;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(rd_status) |-> !reg_rdata_o[1];
  endproperty
  a_idx_zero: assert property (p_idx_zero) else $error("index bit set"); // R14

  // Status read without new event clears the interrupt
  property p_read_clears;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (rd_status && !irq_event_i && !soft_reset_bit_r) |=> !irq_pend_r ##1 !irq_o;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read kept irq"); // R07

  // Alternate status read leaves the interrupt pending
  property p_alt_keeps;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (hit(reg_addr_i, `ATSC_OFF_CTRL, reg_rd_i) && irq_pend_r && !soft_reset_bit_r)
        |=> irq_pend_r;
  endproperty
  a_alt_keeps: assert property (p_alt_keeps) else $error("alt read cleared irq"); // R07

  // Masked interrupt never reaches the host
  property p_mask_blocks;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(interrupt_mask_n_r) |-> !irq_o && !int_bit_o;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked irq output"); // R19

  // Control write lands even while busy
  property p_ctl_busy;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr_ctl && busy_i) |=> soft_reset_bit_r == $past(reg_wdata_i[2]) ##1
        soft_reset_o == $past(reg_wdata_i[2], 2);
  endproperty
  a_ctl_busy: assert property (p_ctl_busy) else $error("control write lost"); // R17

  // Drive address head bits are the inversion of drive/head
  property p_inv_head;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      hit(reg_addr_i, `ATSC_OFF_DRV_ADDR, reg_rd_i) |=>
        reg_rdata_o[5:2] == ~$past(drive_head_r[3:0]) &&
        reg_rdata_o[6] == !$past(write_active_i);
  endproperty
  a_inv_head: assert property (p_inv_head) else $error("drive address wrong"); // R21

  // Drive/head bits 7 and 5 always read as ones
  property p_dh_ones;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      drive_head_r[7] && drive_head_r[5];
  endproperty
  a_dh_ones: assert property (p_dh_ones) else $error("drive/head fixed bits lost"); // R01

  // Block address follows the drive/head and sector bytes
  property p_lba_build;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(nrst_i) |-> lba_o == {$past(drive_head_r[3:0]), $past(cyl_hi_i),
        $past(cyl_lo_i), $past(sector_i)} && mode_o == atsc_mode_e'($past(lba_sel_r));
  endproperty
  a_lba_build: assert property (p_lba_build) else $error("block address wrong"); // R03

  // Head number follows drive/head bits 3-0 one cycle later
  property p_head_follow;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(nrst_i) |-> head_o == $past(drive_head_r[3:0]);
  endproperty
  a_head_follow: assert property (p_head_follow) else $error("head number wrong"); // R04

  // Own card number follows the copy field one cycle later
  property p_own_card;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(nrst_i) |-> own_card_r == $past(copy_card_i);
  endproperty
  a_own_card: assert property (p_own_card) else $error("own card number stale"); // R06

  // Selection flag compares the written card number with our own
  property p_sel_out;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(nrst_i) |-> card_selected_o == $past(card_number_select_r == own_card_r);
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("card selection wrong"); // R05

  // Accepted drive/head write lands with its scheme bit
  property p_dh_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr_dh && !soft_reset_bit_r) |=> drive_head_r[4:0] == $past(reg_wdata_i[4:0]) &&
        lba_sel_r == $past(reg_wdata_i[`ATSC_DH_LBA]);
  endproperty
  a_dh_write: assert property (p_dh_write) else $error("drive/head write lost"); // R02

  // Drive/head write while busy leaves the register alone
  property p_dh_busy;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (hit(reg_addr_i, `ATSC_OFF_DRIVE_HEAD, reg_wr_i) && busy_i && !soft_reset_bit_r)
        |=> $stable(drive_head_r);
  endproperty
  a_dh_busy: assert property (p_dh_busy) else $error("write accepted while busy"); // R08

  // Soft reset returns drive/head to its reset value and drops the interrupt
  property p_srst_clears;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      soft_reset_bit_r |=> drive_head_r == `ATSC_DH_RESET && !irq_pend_r;
  endproperty
  a_srst_clears: assert property (p_srst_clears) else $error("soft reset kept state"); // R18

  // No DMA request while soft reset holds the card
  property p_srst_dma;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      soft_reset_bit_r |=> !dmarq_o;
  endproperty
  a_srst_dma: assert property (p_srst_dma) else $error("dmarq during soft reset"); // R09

  // Status fields mirror the engine levels when not busy
  property p_status_fields;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (rd_status && !busy_i && !soft_reset_bit_r) |=> reg_rdata_o == {1'b0, $past(ready_i),
        $past(write_fault_i), $past(ready_i), $past(drq_i), $past(corrected_error_flag_i), 1'b0, $past(err_i)};
  endproperty
  a_status_fields: assert property (p_status_fields) else $error("status fields wrong"); // R11

  // Alternate status while busy shows only the busy bit too
  property p_alt_busy;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (hit(reg_addr_i, `ATSC_OFF_CTRL, reg_rd_i) && busy_i) |=> reg_rdata_o == 8'h80;
  endproperty
  a_alt_busy: assert property (p_alt_busy) else $error("alt status not masked"); // R07

  // Drive address select bits: one reads low only when the addressed card is ours
  property p_drv_select;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      hit(reg_addr_i, `ATSC_OFF_DRV_ADDR, reg_rd_i) |=>
        (reg_rdata_o[1:0] == 2'h3) == $past(card_number_select_r != own_card_r);
  endproperty
  a_drv_select: assert property (p_drv_select) else $error("drive select bits wrong"); // R22
endmodule : atsc_taskfile
